// ==== hw/mbw_handler.sv ====
// request interpreter for no-save, single and diagnosis functions
// How it works
// - multi write success echoes code, address, count
// - register values travel high byte first
// - running-locked parameter write returns exception 1
// - failure replies code with top bit, exception
// - diagnosis test chosen by sub-function field
// - diagnosis touches no registers or state
// - sub-function zero echoes the data bytes
// - diagnosis reply copies code and sub-function
// - single write commits value to storage
// - single write answers after write completes
// - value is a full sixteen-bit field
// - no-save single write changes RAM only
// - power cycle restores stored value
`timescale 1ns/1ps
`default_nettype none
module mbw_handler
  import mbw_pkg::*;
(
  input wire logic clk_sys_in, // 50 MHz clock
  input wire logic sys_rst_in, // sync reset, high
  input wire logic [7:0] rx_byte_in, // request pdu byte
  input wire logic rx_valid_in, // byte strobe
  input wire logic rx_end_in, // frame end strobe
  input wire logic locked_in, // target is running-locked
  input wire logic wr_done_in, // write acknowledged
  output logic wr_req_out, // write request level
  output logic wr_nv_out, // write also to storage
  output logic [15:0] wr_addr_out, // write address
  output logic [15:0] wr_data_out, // write value
  output logic [7:0] tx_byte_out, // response byte
  output logic tx_valid_out, // response byte valid
  input wire logic tx_ready_in, // response byte taken
  output logic busy_out // request in progress
);
  typedef enum logic [3:0] {
    ST_RX = 4'b0001,
    ST_WR = 4'b0010,
    ST_TX = 4'b0100,
    ST_DRAIN = 4'b1000
  } mbw_state_e;

  mbw_state_e state_reg, state_next;
  logic [7:0] hdr_reg [0:5];
  logic [7:0] hdr_next [0:5];
  logic [5:0] rx_cnt_reg, rx_cnt_next;
  logic [4:0] tx_idx_reg, tx_idx_next, tx_len_reg, tx_len_next;
  logic [7:0] exc_reg, exc_next;
  logic err_reg, err_next;
  logic [4:0] wr_left_reg, wr_left_next;
  logic [15:0] wr_addr_reg, wr_addr_next, wr_data_reg, wr_data_next;
  logic wr_nv_reg, wr_nv_next;
  logic [7:0] data_buf_reg [0:31];
  logic [7:0] tx_byte_reg, tx_byte_next;
  logic [4:0] buf_idx_reg, buf_idx_next;

  logic [15:0] count_w;
  logic [7:0] fc_w;
  assign fc_w = hdr_reg[0];
  assign count_w = {hdr_reg[3], hdr_reg[4]};

  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < 6; i++) begin
      hdr_next[i] = hdr_reg[i];
    end
    rx_cnt_next = rx_cnt_reg;
    tx_idx_next = tx_idx_reg;
    tx_len_next = tx_len_reg;
    exc_next = exc_reg;
    err_next = err_reg;
    wr_left_next = wr_left_reg;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    wr_nv_next = wr_nv_reg;
    buf_idx_next = buf_idx_reg;
    unique case (state_reg)
      ST_RX: begin
        if (rx_valid_in && rx_cnt_reg != 6'h3f) begin
          if (rx_cnt_reg < 6'd6) begin
            hdr_next[rx_cnt_reg[2:0]] = rx_byte_in;
          end
          rx_cnt_next = rx_cnt_reg + 6'd1;
        end
        if (rx_end_in) begin
          rx_cnt_next = 6'd0;
          buf_idx_next = 5'd0;
          err_next = 1'b0;
          tx_idx_next = 5'd0;
          wr_left_next = 5'd1;
          tx_len_next = BYTES_WR;
          state_next = ST_WR;
          unique case (fc_w)
            FC_WR_SINGLE, FC_WR_SINGLE_RAM: begin
              // only write frames touch the write port
              wr_addr_next = {hdr_reg[1], hdr_reg[2]};
              wr_data_next = {hdr_reg[3], hdr_reg[4]};
              wr_nv_next = (fc_w == FC_WR_SINGLE);
              if (rx_cnt_reg != 6'd5) begin
                err_next = 1'b1;
                exc_next = EXC_BAD_VALUE;
              end else if (locked_in) begin
                err_next = 1'b1;
                exc_next = EXC_LOCKED;
              end
            end
            FC_DIAG: begin
              state_next = ST_TX;
              if (rx_cnt_reg != 6'd5) begin
                err_next = 1'b1;
                exc_next = EXC_BAD_VALUE;
              end else if ({hdr_reg[1], hdr_reg[2]} != SUB_ECHO) begin
                err_next = 1'b1;
                exc_next = EXC_ILLEGAL_FUNC;
              end
            end
            FC_WR_MULTI_RAM: begin
              wr_nv_next = 1'b0;
              wr_addr_next = {hdr_reg[1], hdr_reg[2]};
              wr_left_next = count_w[4:0];
              wr_data_next = {data_buf_reg[0], data_buf_reg[1]};
              buf_idx_next = 5'd2;
              tx_len_next = BYTES_WR;
              if (count_w == 16'h0000 || count_w > MAX_REGS ||
                  {8'h00, hdr_reg[5]} != {count_w[14:0], 1'b0} ||
                  rx_cnt_reg != 6'(6 + 2 * count_w[4:0])) begin
                err_next = 1'b1;
                exc_next = EXC_BAD_VALUE;
              end else if (locked_in) begin
                err_next = 1'b1;
                exc_next = EXC_LOCKED;
              end
            end
            default: begin
              err_next = 1'b1;
              exc_next = EXC_ILLEGAL_FUNC;
            end
          endcase
          if (err_next) begin
            tx_len_next = BYTES_EXC;
            state_next = ST_TX;
          end
        end
      end
      ST_WR: begin
        if (wr_done_in) begin
          if (wr_left_reg == 5'd1) begin
            state_next = ST_TX;
          end else begin
            wr_left_next = wr_left_reg - 5'd1;
            wr_addr_next = wr_addr_reg + 16'h0001;
            wr_data_next = {data_buf_reg[buf_idx_reg],
                            data_buf_reg[buf_idx_reg + 5'd1]};
            buf_idx_next = buf_idx_reg + 5'd2;
          end
        end
      end
      ST_TX: begin
        if (tx_ready_in) begin
          if (tx_idx_reg == tx_len_reg - 5'd1) begin
            state_next = ST_RX;
          end else begin
            tx_idx_next = tx_idx_reg + 5'd1;
          end
        end
      end
      ST_DRAIN: begin
        state_next = ST_RX;
      end
    endcase
  end

  // response bytes: header echo, or error code then exception; picked
  // from the next-state values so the byte leaves a flip-flop in step
  always_comb begin
    tx_byte_next = 8'h00;
    if (err_next) begin
      tx_byte_next = exc_next;
      if (tx_idx_next == 5'd0) begin
        tx_byte_next = hdr_next[0] | FC_ERR_BIT;
      end
    end else if (tx_idx_next < MAX_BYTES) begin
      tx_byte_next = hdr_next[tx_idx_next[2:0]];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_RX;
      for (int i = 0; i < 6; i++) begin
        hdr_reg[i] <= 8'h00;
      end
      rx_cnt_reg <= 6'd0;
      tx_idx_reg <= 5'd0;
      tx_len_reg <= 5'd0;
      exc_reg <= 8'h00;
      err_reg <= 1'b0;
      wr_left_reg <= 5'd0;
      wr_addr_reg <= 16'h0000;
      wr_data_reg <= 16'h0000;
      wr_nv_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      buf_idx_reg <= 5'd0;
    end else begin
      state_reg <= state_next;
      for (int i = 0; i < 6; i++) begin
        hdr_reg[i] <= hdr_next[i];
      end
      rx_cnt_reg <= rx_cnt_next;
      tx_idx_reg <= tx_idx_next;
      tx_len_reg <= tx_len_next;
      exc_reg <= exc_next;
      err_reg <= err_next;
      wr_left_reg <= wr_left_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      wr_nv_reg <= wr_nv_next;
      tx_byte_reg <= tx_byte_next;
      buf_idx_reg <= buf_idx_next;
    end
  end

  // value bytes of a multi write, kept in arrival order
  always_ff @(posedge clk_sys_in) begin
    if (state_reg == ST_RX && rx_valid_in && rx_cnt_reg >= 6'd6 &&
        rx_cnt_reg < 6'd38) begin
      data_buf_reg[5'(rx_cnt_reg - 6'd6)] <= rx_byte_in;
    end
  end

  assign tx_byte_out = tx_byte_reg;
  assign tx_valid_out = (state_reg == ST_TX);
  assign wr_req_out = (state_reg == ST_WR);
  assign wr_nv_out = wr_nv_reg;
  assign wr_addr_out = wr_addr_reg;
  assign wr_data_out = wr_data_reg;
  assign busy_out = (state_reg != ST_RX);

  a_diag_no_write: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (state_reg == ST_RX && rx_end_in && fc_w == FC_DIAG) |=>
      !wr_req_out [*2])
    else $error("diagnosis request caused a write");
  a_ram_only: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (wr_req_out && fc_w != FC_WR_SINGLE) |-> !wr_nv_out)
    else $error("no-save write reached storage");
  a_single_nv: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (wr_req_out && fc_w == FC_WR_SINGLE) |-> wr_nv_out)
    else $error("single write not committed");
  a_err_code: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (tx_valid_out && err_reg && tx_idx_reg == 5'd0) |->
      tx_byte_out == (fc_w | FC_ERR_BIT))
    else $error("error code lacks top bit");
  a_echo_hdr: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (tx_valid_out && !err_reg && tx_idx_reg == 5'd0) |->
      tx_byte_out == fc_w)
    else $error("function code not echoed");
  a_resp_after_wr: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    ($rose(tx_valid_out) && $past(wr_req_out)) |->
      $past(wr_done_in))
    else $error("response before write done");
  a_bad_count: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (state_reg == ST_RX && rx_end_in && fc_w == FC_WR_MULTI_RAM &&
     (count_w == 16'h0000 || count_w > MAX_REGS)) |=>
      err_reg && !wr_req_out)
    else $error("bad count accepted");
  a_locked_exc: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (state_reg == ST_RX && rx_end_in && fc_w == FC_WR_MULTI_RAM &&
     locked_in) |=> err_reg && !wr_req_out &&
      (exc_reg == EXC_LOCKED || exc_reg == EXC_BAD_VALUE))
    else $error("locked write not refused");
endmodule : mbw_handler
`default_nettype wire

// ==== hw/mbw_pkg.sv ====
// constants for the request write and diagnosis handler
package mbw_pkg;
  localparam logic [7:0] FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WR_SINGLE_RAM = 8'h41;
  localparam logic [7:0] FC_WR_MULTI_RAM = 8'h42;
  localparam logic [7:0] FC_ERR_BIT = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
  localparam logic [7:0] EXC_LOCKED = 8'h01;
  localparam logic [15:0] SUB_ECHO = 16'h0000;
  localparam logic [15:0] MAX_REGS = 16'h0010;
  localparam logic [4:0] MAX_BYTES = 5'd6;
  localparam logic [4:0] BYTES_WR = 5'd5;
  localparam logic [4:0] BYTES_EXC = 5'd2;
  localparam logic [4:0] BYTES_HDR_MULTI = 5'd6;
endpackage : mbw_pkg

// ==== tb/mbw_handler_test.sv ====
// self-checking bench for the request handler
`timescale 1ns/1ps
`default_nettype none
module mbw_handler_test;
  import mbw_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic locked = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rx_byte, tx_byte;
  logic rx_valid, rx_end, wr_done, tx_ready, wr_req, wr_nv, tx_valid, busy;
  logic [15:0] wr_addr, wr_data;
  int n_errors = 0;
  int checked = 0;
  always #10 clk = ~clk;
  mbw_handler mbw_handler_i (.clk_sys_in(clk), .sys_rst_in(rst),
    .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_end_in(rx_end),
    .locked_in(locked), .wr_done_in(wr_done), .wr_req_out(wr_req),
    .wr_nv_out(wr_nv), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
    .tx_byte_out(tx_byte), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready), .busy_out(busy));
  mbw_master_model mbw_master_model_i (.clk_in(clk), .rst_in(rst),
    .slow_in(slow), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
    .rx_end_out(rx_end), .wr_done_out(wr_done), .tx_ready_out(tx_ready),
    .wr_req_in(wr_req), .wr_nv_in(wr_nv), .wr_addr_in(wr_addr),
    .wr_data_in(wr_data), .tx_byte_in(tx_byte), .tx_valid_in(tx_valid));
  task automatic chk_n(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_rsp(input logic [7:0] e[$]);
    chk_n(mbw_master_model_i.rsp.size(), e.size(), "response length");
    foreach (e[i]) begin
      checked++;
      if (mbw_master_model_i.rsp[i] !== e[i]) begin
        n_errors++;
        $display("wrong value at %0t: response byte %0d", $time, i);
      end
    end
  endtask
  task automatic chk_wrs(input logic [32:0] e[$]);
    chk_n(mbw_master_model_i.wrs.size(), e.size(), "write count");
    foreach (e[i]) begin
      checked++;
      if (mbw_master_model_i.wrs[i] !== e[i]) begin
        n_errors++;
        $display("wrong value at %0t: write %0d", $time, i);
      end
    end
  endtask
  task automatic run(input string nm, input logic lk, input logic [7:0] f[$],
    input logic [7:0] er[$], input logic [32:0] ew[$]);
    int n;
    n = 0;
    locked <= lk;
    mbw_master_model_i.rsp.delete();
    mbw_master_model_i.wrs.delete();
    mbw_master_model_i.send(f);
    @(posedge clk);
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk_n(n < 400, 1, "busy never fell");
    chk_rsp(er);
    chk_wrs(ew);
    $display("test %s done", nm);
  endtask
  task automatic t_multi();
    logic [7:0] f[$];
    logic [32:0] w[$];
    f = '{FC_WR_MULTI_RAM, 8'h00, 8'h0e, 8'h00, 8'h10, 8'h20};
    for (int i = 0; i < 16; i++) begin
      f.push_back(8'(i));
      f.push_back(8'hf0 ^ 8'(i));
      w.push_back({1'b0, 16'h000e + 16'(i), 8'(i), 8'hf0 ^ 8'(i)});
    end
    slow <= 1'b1;
    run("multi", 1'b0, f, '{8'h42, 8'h00, 8'h0e, 8'h00, 8'h10}, w);
    slow <= 1'b0;
  endtask
  task automatic t_locked();
    run("locked", 1'b1, '{8'h42, 8'h00, 8'h0e, 8'h00, 8'h01, 8'h02, 8'h01,
      8'hf4}, '{8'hc2, EXC_LOCKED}, '{});
  endtask
  task automatic t_bad();
    run("count0", 1'b0, '{8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
      '{8'hc2, EXC_BAD_VALUE}, '{});
    run("count17", 1'b0, '{8'h42, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22},
      '{8'hc2, EXC_BAD_VALUE}, '{});
    run("bytes", 1'b0, '{8'h42, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h00,
      8'h00}, '{8'hc2, EXC_BAD_VALUE}, '{});
  endtask
  task automatic t_diag();
    slow <= 1'b1;
    run("echo", 1'b0, '{8'h08, 8'h00, 8'h00, 8'ha5, 8'h37},
      '{8'h08, 8'h00, 8'h00, 8'ha5, 8'h37}, '{});
    slow <= 1'b0;
    run("subfn", 1'b0, '{8'h08, 8'h00, 8'h01, 8'ha5, 8'h37},
      '{8'h88, 8'h01}, '{});
  endtask
  task automatic t_single();
    run("single", 1'b0, '{8'h06, 8'h00, 8'h01, 8'h00, 8'h01},
      '{8'h06, 8'h00, 8'h01, 8'h00, 8'h01}, '{33'h1_0001_0001});
    run("singlemax", 1'b0, '{8'h06, 8'hff, 8'hff, 8'hff, 8'hff},
      '{8'h06, 8'hff, 8'hff, 8'hff, 8'hff}, '{33'h1_ffff_ffff});
    chk_n(mbw_master_model_i.wr_at_rsp, 1, "early response");
    run("single err", 1'b0, '{8'h06, 8'h00, 8'h01},
      '{8'h86, EXC_BAD_VALUE}, '{});
  endtask
  task automatic t_ram();
    // frequently changed value goes through the no-save write
    run("ram", 1'b0, '{8'h41, 8'h00, 8'h07, 8'h13, 8'h88},
      '{8'h41, 8'h00, 8'h07, 8'h13, 8'h88}, '{33'h0_0007_1388});
    run("unknown", 1'b0, '{8'h03, 8'h00, 8'h00, 8'h00, 8'h01},
      '{8'h83, EXC_ILLEGAL_FUNC}, '{});
  endtask
  task automatic test_done();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_multi();
    t_locked();
    t_bad();
    t_diag();
    t_single();
    t_ram();
    test_done();
  end
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule // mbw_handler_test
`default_nettype wire

// ==== tb/mbw_master_model.sv ====
// master station and write store model facing the request handler
`timescale 1ns/1ps
`default_nettype none
module mbw_master_model (
  input wire logic clk_in, // clock
  input wire logic rst_in, // sync reset
  input wire logic slow_in, // stall response bytes
  output logic [7:0] rx_byte_out, // request byte
  output logic rx_valid_out, // byte strobe
  output logic rx_end_out, // frame end strobe
  output logic wr_done_out, // write taken
  output logic tx_ready_out, // response byte taken
  input wire logic wr_req_in, // write pending
  input wire logic wr_nv_in, // storage commit
  input wire logic [15:0] wr_addr_in, // write address
  input wire logic [15:0] wr_data_in, // write value
  input wire logic [7:0] tx_byte_in, // response byte
  input wire logic tx_valid_in // response valid
);
  logic [7:0] rsp[$];
  logic [32:0] wrs[$];
  int wr_at_rsp = 0;
  int dly = 0;
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_end_out = 1'b0;
    wr_done_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // frames arrive whole, values high byte first
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge clk_in);
      rx_byte_out <= f[i];
      rx_valid_out <= 1'b1;
    end
    @(posedge clk_in);
    rx_byte_out <= ~rx_byte_out;
    rx_valid_out <= 1'b0;
    rx_end_out <= 1'b1;
    @(posedge clk_in);
    rx_end_out <= 1'b0;
  endtask
  // each write is taken a few cycles after it is requested
  always @(posedge clk_in) begin
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
    wr_done_out <= 1'b0;
    // writes already finished when the first response byte leaves
    if (tx_valid_in && tx_ready_out && rsp.size() == 0) begin
      wr_at_rsp <= wrs.size();
    end
    if (tx_valid_in && tx_ready_out) rsp.push_back(tx_byte_in);
    if (wr_done_out) wrs.push_back({wr_nv_in, wr_addr_in, wr_data_in});
    if (rst_in) dly <= 0;
    else if (wr_req_in && !wr_done_out) begin
      dly <= (dly == 2) ? 0 : dly + 1;
      wr_done_out <= (dly == 2);
    end
  end
endmodule // mbw_master_model
`default_nettype wire
